// *** logic/alu_status_flag_register.sv ***
// Local design decisions: the address map and the AXI4-Lite slave port.
`include "flag_defines.svh"

module alu_status_flag_register #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic [ADDR_W-1:0] awaddr_i,
   input  wire logic              awvalid_i,
   output logic                   awready_o,
   input  wire logic [31:0]       wdata_i,
   input  wire logic [3:0]        wstrb_i,
   input  wire logic              wvalid_i,
   output logic                   wready_o,
   output logic [1:0]             bresp_o,
   output logic                   bvalid_o,
   input  wire logic              bready_i,
   input  wire logic [ADDR_W-1:0] araddr_i,
   input  wire logic              arvalid_i,
   output logic                   arready_o,
   output logic [31:0]            rdata_o,
   output logic [1:0]             rresp_o,
   output logic                   rvalid_o,
   input  wire logic              rready_i,
   output logic [`FLG_W-1:0]      flags_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   logic [`FLG_W-1:0] flags_q;
   logic [7:0]        accum_q;
   logic [7:0]        file_q;
   logic [7:0]        result_q;
   logic [`ISS_W-1:0] issue_q;
   logic              awready_q;
   logic              wready_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              arready_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [31:0]       rdata_q;

   logic              wr_go;
   logic              rd_go;
   logic [7:0]        waddr;
   logic [7:0]        raddr;
   logic              wr_lane0;
   logic              wr_hit;
   logic              exec;
   logic              dest_flags;
   logic              src_flags;
   flag_pkg::op_e     op;
   logic [2:0]        bit_sel;
   logic [7:0]        file_opnd;
   logic [7:0]        alu_result;
   logic [`FLG_W-1:0] alu_flags;
   logic [`FLG_W-1:0] affect;
   logic [`FLG_W-1:0] merged;
   logic [`FLG_W-1:0] exec_affect;
   logic [31:0]       rdata_d;
   logic              rd_hit;
   logic              wsel_flags;
   logic              wsel_accum;
   logic              wsel_file;
   logic              wsel_issue;
   logic              data_lands;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign wr_go    = awvalid_i && awready_q && wvalid_i && wready_q;
   assign rd_go    = arvalid_i && arready_q;
   assign waddr    = awaddr_i[7:0];
   assign raddr    = araddr_i[7:0];
   assign wr_lane0 = wr_go && wstrb_i[0];
   assign wr_hit   = (waddr == `OFF_FLAGS) || (waddr == `OFF_ACCUM) ||
                     (waddr == `OFF_FILE) || (waddr == `OFF_ISSUE) ||
                     (waddr == `OFF_RESULT);

   // One select per writable register (result has none); without lane 0 a write is answered but changes nothing
   assign wsel_flags = wr_lane0 && (waddr == `OFF_FLAGS);
   assign wsel_accum = wr_lane0 && (waddr == `OFF_ACCUM);
   assign wsel_file  = wr_lane0 && (waddr == `OFF_FILE);
   assign wsel_issue = wr_lane0 && (waddr == `OFF_ISSUE);

   // An issue write runs the instruction in the same edge it is taken
   assign exec       = wsel_issue;
   assign op         = flag_pkg::op_e'(wdata_i[`ISS_OP_MSB:`ISS_OP_LSB]);
   assign bit_sel    = wdata_i[`ISS_BIT_MSB:`ISS_BIT_LSB];
   assign dest_flags = wdata_i[`ISS_DEST];
   assign src_flags  = wdata_i[`ISS_SRC] && wstrb_i[1];

   // Flag register read as a plain operand, upper bits zero
   assign file_opnd = src_flags ? {3'h0, flags_q} : file_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Datapath

   flag_alu u_alu (
      .file_i    (file_opnd),
      .accum_i   (accum_q),
      .bit_sel_i (bit_sel),
      .carry_i   (flags_q[`FLG_C]),
      .op_i      (op),
      .result_o  (alu_result),
      .flags_o   (alu_flags),
      .affect_o  (affect)
   );

   assign exec_affect = exec ? affect : '0;

   // Any flag the instruction affects blocks the data write to all five bits
   assign data_lands  = exec && dest_flags && (affect == '0);

   for (genvar i = 0; i < `FLG_W; i++) begin : g_cell
      flag_bit_cell u_cell (
         .old_i    (flags_q[i]),
         .alu_i    (alu_flags[i]),
         .data_i   (alu_result[i]),
         .affect_i (exec_affect[i]),
         .dest_i   (data_lands),
         .new_o    (merged[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   // Flags carry no reset value; software must load them before trusting them
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (wsel_flags) begin
            flags_q <= wdata_i[`FLG_W-1:0];
         end else if (exec) begin
            flags_q <= merged;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accum_q <= 8'h00;
      end else if (ce_i && wsel_accum) begin
         accum_q <= wdata_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         file_q <= 8'h00;
      end else if (ce_i) begin
         if (wsel_file) begin
            file_q <= wdata_i[7:0];
         end else if (exec && !dest_flags) begin
            file_q <= alu_result;
         end
      end
   end

   // Result keeps the raw ALU value even when the flag write was blocked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_q <= 8'h00;
      end else if (ce_i && exec) begin
         result_q <= alu_result;
      end
   end

   // Last issue word kept for read-back, with the source bit as it was qualified
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         issue_q <= '0;
      end else if (ce_i && exec) begin
         issue_q <= {src_flags, wdata_i[`ISS_DEST:0]};
      end
   end

   // Flag output is one cycle behind the register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_o <= '0;
      end else if (ce_i) begin
         flags_o <= flags_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data are taken together

   // Address and data are only taken as a pair, so a lone channel waits for its partner
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         awready_q <= 1'b0;
      end else if (ce_i) begin
         if (awready_q) begin
            awready_q <= 1'b0;
         end else if (awvalid_i && wvalid_i && !bvalid_q) begin
            awready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wready_q <= 1'b0;
      end else if (ce_i) begin
         if (wready_q) begin
            wready_q <= 1'b0;
         end else if (awvalid_i && wvalid_i && !bvalid_q) begin
            wready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bvalid_q <= 1'b0;
      end else if (ce_i) begin
         if (wr_go) begin
            bvalid_q <= 1'b1;
         end else if (bready_i) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Response code only moves when a write is taken, so it stands with bvalid
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bresp_q <= `RESP_OKAY;
      end else if (ce_i && wr_go) begin
         bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read channel

   always_comb begin
      rdata_d = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (raddr)
         `OFF_FLAGS:  rdata_d[`FLG_W-1:0] = flags_q;
         `OFF_ACCUM:  rdata_d[7:0]        = accum_q;
         `OFF_FILE:   rdata_d[7:0]        = file_q;
         `OFF_ISSUE:  rdata_d[`ISS_W-1:0] = issue_q;
         `OFF_RESULT: rdata_d[7:0]        = result_q;
         default:     rd_hit              = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arready_q <= 1'b0;
      end else if (ce_i) begin
         arready_q <= !arready_q && arvalid_i && !rvalid_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rvalid_q <= 1'b0;
      end else if (ce_i) begin
         if (rd_go) begin
            rvalid_q <= 1'b1;
         end else if (rready_i) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Read payload only loads on a taken read, so it stands until rready
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rresp_q <= `RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else if (ce_i && rd_go) begin
         rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         rdata_q <= rdata_d;
      end
   end

   assign awready_o = awready_q;
   assign wready_o  = wready_q;
   assign bvalid_o  = bvalid_q;
   assign bresp_o   = bresp_q;
   assign arready_o = arready_q;
   assign rvalid_o  = rvalid_q;
   assign rresp_o   = rresp_q;
   assign rdata_o   = rdata_q;

endmodule

// *** logic/flag_alu.sv ***
`include "flag_defines.svh"

module flag_alu (
   input  wire logic [7:0]        file_i,
   input  wire logic [7:0]        accum_i,
   input  wire logic [2:0]        bit_sel_i,
   input  wire logic              carry_i,
   input  wire flag_pkg::op_e     op_i,
   output logic      [7:0]        result_o,
   output logic      [`FLG_W-1:0] flags_o,
   output logic      [`FLG_W-1:0] affect_o
);

   logic [7:0] addend;
   logic       sub;
   logic [8:0] sum;
   logic [4:0] nib;
   logic       carry_new;
   logic       signed_wrap;
   logic       half_byte_out;

   // Subtraction adds the two's complement, so carry reads as not-borrow
   always_comb begin
      sub    = (op_i == flag_pkg::OP_SUB);
      addend = sub ? ~accum_i : accum_i;
      sum    = {1'b0, file_i} + {1'b0, addend} + {8'h00, sub};
      nib    = {1'b0, file_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub};
   end

   always_comb begin
      result_o  = file_i;
      carry_new = carry_i;
      affect_o  = '0;
      unique case (op_i)
         flag_pkg::OP_ADD, flag_pkg::OP_SUB: begin
            result_o  = sum[7:0];
            carry_new = sum[8];
            affect_o  = '1;
         end
         flag_pkg::OP_AND: begin
            result_o                = file_i & accum_i;
            affect_o[`FLG_Z]        = 1'b1;
            affect_o[`FLG_N]        = 1'b1;
         end
         flag_pkg::OP_IOR: begin
            result_o                = file_i | accum_i;
            affect_o[`FLG_Z]        = 1'b1;
            affect_o[`FLG_N]        = 1'b1;
         end
         flag_pkg::OP_XOR: begin
            result_o                = file_i ^ accum_i;
            affect_o[`FLG_Z]        = 1'b1;
            affect_o[`FLG_N]        = 1'b1;
         end
         flag_pkg::FILE_ZERO_OP: begin
            result_o                = 8'h00;
            affect_o[`FLG_Z]        = 1'b1;
         end
         // These leave every flag alone
         flag_pkg::BIT_CLEAR_OP: result_o = file_i & ~(8'h01 << bit_sel_i);
         flag_pkg::BIT_SET_OP:   result_o = file_i | (8'h01 << bit_sel_i);
         flag_pkg::NIBBLE_SWAP_OP: result_o = {file_i[3:0], file_i[7:4]};
         flag_pkg::FILE_TO_FILE_MOVE:  result_o = file_i;
         flag_pkg::ACCUM_TO_FILE_MOVE: result_o = accum_i;
         flag_pkg::OP_ROT_LEFT: begin
            result_o                = {file_i[6:0], carry_i};
            carry_new               = file_i[7];
            affect_o[`FLG_C]        = 1'b1;
            affect_o[`FLG_Z]        = 1'b1;
            affect_o[`FLG_N]        = 1'b1;
         end
         flag_pkg::OP_ROT_RIGHT: begin
            result_o                = {carry_i, file_i[7:1]};
            carry_new               = file_i[0];
            affect_o[`FLG_C]        = 1'b1;
            affect_o[`FLG_Z]        = 1'b1;
            affect_o[`FLG_N]        = 1'b1;
         end
         default: begin
            result_o = file_i;
         end
      endcase
   end

   always_comb begin
      signed_wrap   = (file_i[7] == addend[7]) && (sum[7] != file_i[7]);
      half_byte_out = nib[`NIB_CARRY];
      flags_o[`FLG_N]  = result_o[7];
      flags_o[`FLG_OV] = signed_wrap;
      flags_o[`FLG_Z]  = (result_o == 8'h00);
      flags_o[`FLG_DC] = half_byte_out;
      flags_o[`FLG_C]  = carry_new;
   end

endmodule

// *** logic/flag_bit_cell.sv ***
module flag_bit_cell (
   input  wire logic old_i,
   input  wire logic alu_i,
   input  wire logic data_i,
   input  wire logic affect_i,
   input  wire logic dest_i,
   output logic      new_o
);

   // ALU value beats the data write on a flag the instruction affects
   assign new_o = affect_i ? alu_i : (dest_i ? data_i : old_i);

endmodule

// *** logic/flag_defines.svh ***
`ifndef FLAG_DEFINES_SVH
`define FLAG_DEFINES_SVH

// Register byte offsets
`define OFF_FLAGS    8'h00
`define OFF_ACCUM    8'h04
`define OFF_FILE     8'h08
`define OFF_ISSUE    8'h0C
`define OFF_RESULT   8'h10

// Flag bit positions
`define FLG_C        0
`define FLG_DC       1
`define FLG_Z        2
`define FLG_OV       3
`define FLG_N        4
`define FLG_W        5

// Issue register fields
`define ISS_OP_LSB   0
`define ISS_OP_MSB   3
`define ISS_BIT_LSB  4
`define ISS_BIT_MSB  6
`define ISS_DEST     7
`define ISS_SRC      8
`define ISS_W        9

// Carry out of the low nibble sits here in the nibble sum
`define NIB_CARRY    4

// Bus responses
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// *** logic/flag_pkg.sv ***
package flag_pkg;

   typedef enum logic [3:0] {
      OP_ADD             = 4'h0,
      OP_SUB             = 4'h1,
      OP_AND             = 4'h2,
      OP_IOR             = 4'h3,
      OP_XOR             = 4'h4,
      FILE_ZERO_OP       = 4'h5,
      BIT_CLEAR_OP       = 4'h6,
      BIT_SET_OP         = 4'h7,
      NIBBLE_SWAP_OP     = 4'h8,
      FILE_TO_FILE_MOVE  = 4'h9,
      ACCUM_TO_FILE_MOVE = 4'hA,
      OP_ROT_LEFT        = 4'hB,
      OP_ROT_RIGHT       = 4'hC
   } op_e;

endpackage

// *** verif/alu_status_flag_register_asserts.sv ***
`include "flag_defines.svh"

module alu_status_flag_register_asserts #(
   parameter int ADDR_W = 8
) (
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              ce_i,
   input wire logic [ADDR_W-1:0] awaddr_i,
   input wire logic              awvalid_i,
   input wire logic              awready_o,
   input wire logic [31:0]       wdata_i,
   input wire logic [3:0]        wstrb_i,
   input wire logic              wvalid_i,
   input wire logic              wready_o,
   input wire logic [1:0]        bresp_o,
   input wire logic              bvalid_o,
   input wire logic              bready_i,
   input wire logic [ADDR_W-1:0] araddr_i,
   input wire logic              arvalid_i,
   input wire logic              arready_o,
   input wire logic [31:0]       rdata_o,
   input wire logic [1:0]        rresp_o,
   input wire logic              rvalid_o,
   input wire logic              rready_i,
   input wire logic [4:0]        flags_o
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence wr_take;
      ce_i && awvalid_i && wvalid_i && awready_o && wready_o;
   endsequence
   sequence rd_take;
      ce_i && arvalid_i && arready_o;
   endsequence

   aw_w_pair_a: assert property (awready_o == wready_o) else $error("aw and w ready split");
   aw_pulse_a: assert property (awready_o |=> !awready_o) else $error("awready held");
   wr_busy_a: assert property (bvalid_o |-> !awready_o) else $error("write taken while busy");
   wr_resp_a: assert property (wr_take |=> bvalid_o) else $error("write response late");
   rd_resp_a: assert property (rd_take |=> rvalid_o) else $error("read response late");
   b_hold_a: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
      else $error("write response dropped");
   r_hold_a: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
      else $error("read data dropped");
   err_zero_a: assert property (rvalid_o && rresp_o == `RESP_SLVERR |-> rdata_o == 32'h0)
      else $error("error read carries data");
   flag_top_a: assert property (rd_take ##0 (araddr_i == `OFF_FLAGS) |=>
      rdata_o[31:5] == 27'h0) else $error("flag upper bits not zero");
   // Read data and flag output both show the register as it stood at the read
   flag_view_a: assert property (rd_take ##0 (araddr_i == `OFF_FLAGS) |=>
      rdata_o[4:0] == flags_o) else $error("flag read disagrees with output");
   // Bus write lands in full; flag output lags the register one cycle
   flag_land_a: assert property (wr_take ##0 (awaddr_i == `OFF_FLAGS && wstrb_i[0]) |->
      ##2 flags_o == $past(wdata_i[4:0], 2)) else $error("flag write lost");
endmodule

bind alu_status_flag_register alu_status_flag_register_asserts #(.ADDR_W(ADDR_W)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
   .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
   .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
   .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o),
   .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i), .flags_o(flags_o));

// *** verif/alu_status_flag_register_tb.sv ***
`include "flag_defines.svh"

module alu_status_flag_register_tb;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {
      logic [7:0] init;
      logic [7:0] f;
      logic [7:0] a;
      logic [3:0] op;
      logic       dest;
      logic       src;
      logic [2:0] bn;
      logic [4:0] fl;
      logic [7:0] res;
   } row_s;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic [7:0]  awaddr_i = 8'h00;
   logic [7:0]  araddr_i = 8'h00;
   logic        awvalid_i = 1'b0;
   logic        wvalid_i = 1'b0;
   logic        bready_i = 1'b0;
   logic        arvalid_i = 1'b0;
   logic        rready_i = 1'b0;
   logic [31:0] wdata_i = 32'h0;
   logic [3:0]  wstrb_i = 4'hF;
   logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
   logic [1:0]  bresp_o, rresp_o, rs;
   logic [31:0] rdata_o, rd_d;
   logic [4:0]  flags_o;
   int          bad_count = 0;
   int          cmp_count = 0;

   // Flag-affecting ops aimed at the flag register keep old values in unaffected bits
   row_s rows [17] = '{
      '{8'h00, 8'h7F, 8'h01, 4'h0, 1'b0, 1'b0, 3'h0, 5'h1A, 8'h80},
      '{8'h00, 8'hFF, 8'h01, 4'h0, 1'b0, 1'b0, 3'h0, 5'h07, 8'h00},
      '{8'h00, 8'h05, 8'h03, 4'h1, 1'b0, 1'b0, 3'h0, 5'h03, 8'h02},
      '{8'h1F, 8'h03, 8'h05, 4'h1, 1'b0, 1'b0, 3'h0, 5'h10, 8'hFE},
      '{8'h00, 8'h80, 8'h01, 4'h1, 1'b0, 1'b0, 3'h0, 5'h09, 8'h7F},
      '{8'h0B, 8'h0F, 8'hF0, 4'h2, 1'b1, 1'b0, 3'h0, 5'h0F, 8'h00},
      '{8'h13, 8'h55, 8'h00, 4'h5, 1'b1, 1'b0, 3'h0, 5'h17, 8'h00},
      '{8'h00, 8'h00, 8'h00, 4'h7, 1'b1, 1'b1, 3'h3, 5'h08, 8'h08},
      '{8'h1F, 8'h00, 8'h00, 4'h6, 1'b1, 1'b1, 3'h0, 5'h1E, 8'h1E},
      '{8'h01, 8'h00, 8'h00, 4'h8, 1'b1, 1'b1, 3'h0, 5'h10, 8'h10},
      '{8'h00, 8'h15, 8'h00, 4'h9, 1'b1, 1'b0, 3'h0, 5'h15, 8'h15},
      '{8'h00, 8'h00, 8'h0A, 4'hA, 1'b1, 1'b0, 3'h0, 5'h0A, 8'h0A},
      '{8'h1B, 8'h55, 8'h55, 4'h4, 1'b0, 1'b0, 3'h0, 5'h0F, 8'h00},
      '{8'h04, 8'h80, 8'h01, 4'h3, 1'b0, 1'b0, 3'h0, 5'h10, 8'h81},
      '{8'h18, 8'hFF, 8'h01, 4'h0, 1'b1, 1'b0, 3'h0, 5'h07, 8'h00},
      '{8'h0A, 8'h81, 8'h00, 4'hB, 1'b0, 1'b0, 3'h0, 5'h0B, 8'h02},
      '{8'h01, 8'h02, 8'h00, 4'hC, 1'b0, 1'b0, 3'h0, 5'h10, 8'h81}
   };

   always #5 clk_i = ~clk_i;

   alu_status_flag_register #(.ADDR_W(8)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
      .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
      .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
      .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o),
      .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i), .flags_o(flags_o));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // Outputs are read at the edge before their flops update, so no race
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      awaddr_i <= a;
      wdata_i <= d;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      bready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (!(awready_o && wready_o) && n < 50);
      awvalid_i <= 1'b0;
      wvalid_i <= 1'b0;
      while (!bvalid_o && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      r = bresp_o;
      bready_i <= 1'b0;
      if (n >= 50) begin
         bad_count++;
         complete_run();
      end
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr_i <= a;
      arvalid_i <= 1'b1;
      rready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (!arready_o && n < 50);
      arvalid_i <= 1'b0;
      while (!rvalid_o && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      d = rdata_o;
      r = rresp_o;
      rready_i <= 1'b0;
      if (n >= 50) begin
         bad_count++;
         complete_run();
      end
      @(posedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk_i);
      chk({25'h0, bvalid_o, rvalid_o, flags_o}, 32'h0);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Only the five safe ops alter flags directly; the rest land via the ALU
      foreach (rows[i]) begin
         wr(`OFF_FLAGS, {24'h0, rows[i].init}, rs);
         wr(`OFF_ACCUM, {24'h0, rows[i].a}, rs);
         wr(`OFF_FILE, {24'h0, rows[i].f}, rs);
         wr(`OFF_ISSUE, {23'h0, rows[i].src, rows[i].dest, rows[i].bn, rows[i].op}, rs);
         rd(`OFF_FLAGS, rd_d, rs);
         chk(rd_d, {27'h0, rows[i].fl});
         rd(`OFF_RESULT, rd_d, rs);
         chk(rd_d, {24'h0, rows[i].res});
         chk({27'h0, flags_o}, {27'h0, rows[i].fl});
         rd(`OFF_FILE, rd_d, rs);
         chk(rd_d, {24'h0, (rows[i].dest ? rows[i].f : rows[i].res)});
      end
      rd(`OFF_ISSUE, rd_d, rs);
      chk(rd_d, 32'h0000_000C);
      wr(`OFF_FLAGS, 32'hFFFF_FFFF, rs);
      chk({30'h0, rs}, {30'h0, `RESP_OKAY});
      rd(`OFF_FLAGS, rd_d, rs);
      chk(rd_d, 32'h1F);
      // Clock enable low: a full write offer is ignored and the flags stay frozen
      ce_i <= 1'b0;
      awaddr_i <= `OFF_FLAGS;
      wdata_i <= 32'h0;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk({30'h0, awready_o, bvalid_o}, 32'h0);
      chk({27'h0, flags_o}, 32'h1F);
      awvalid_i <= 1'b0;
      wvalid_i <= 1'b0;
      ce_i <= 1'b1;
      @(posedge clk_i);
      wr(8'h20, 32'h0, rs);
      chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
      rd(8'h20, rd_d, rs);
      chk({rd_d[29:0], rs}, {30'h0, `RESP_SLVERR});
      // Second reset mid-run must clear the handshake and flag outputs
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({25'h0, bvalid_o, rvalid_o, flags_o}, 32'h0);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wr(`OFF_FLAGS, 32'h15, rs);
      rd(`OFF_FLAGS, rd_d, rs);
      chk(rd_d, 32'h15);
      complete_run();
   end
endmodule
